// *** logic/rail_timing_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts
 * for the rail ramp and shutdown timing block.
 * Assumes a 20 MHz core clock and a 32-bit classic Wishbone bus.
 */
`ifndef RAIL_TIMING_MAP_SVH
`define RAIL_TIMING_MAP_SVH

// ==========================================================
// Register map (byte addresses, word aligned)
`define RAMP_TIMING_IDX 8'h5a
`define RAMP_TIMING_ADDR 10'h168
`define OFF_DELAY_ADDR 10'h16c
`define SEQ_CTRL_ADDR 10'h170
`define SEQ_STATUS_ADDR 10'h174

// ==========================================================
// Field positions and reset values
`define SOFT_LSB 6
`define SHUT_LSB 4
`define SLEW_LSB 2
`define SOFT_RST 2'h1
`define SHUT_RST 2'h1
`define SLEW_RST 2'h2
`define OFF_DELAY_RST 7'h00
`define OPT_RST 2'h0

// ==========================================================
// Timing: clock rate and unit times
`define CLK_HZ 20000000
`define HALF_MS_US 500
`define HALF_MS_CYC (`CLK_HZ / 1000000 * `HALF_MS_US)
`define STEP_US 1
`define STEP_CYC (`CLK_HZ / 1000000 * `STEP_US)
`define SLEW_BASE_MV_PER_US 2
`define MS_CYC (`STEP_CYC * 1000)
`define FOUR_MS_TICKS 9'h008
`define OPT_NO_SLEW 2'h3
`define SLEW_OUT_RST 5'h02

`endif

// *** logic/rail_timing_pkg.sv ***
/*
 * Types shared by the rail timing block.
 * Assumes the map header supplies all numeric values.
 */
package rail_timing_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_ACTIVE,
        SEQ_OFF_DELAY,
        SEQ_WAIT_LAST,
        SEQ_SHUTDOWN,
        SEQ_STANDBY,
        SEQ_RESET
    } seq_state_t;

    // ==========================================================
    // Classic Wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    // Timing settings handed to the ramp logic
    typedef struct packed {
        logic [1:0] soft_start;
        logic [1:0] shutdown;
        logic [1:0] slew;
        logic [6:0] off_delay;
    } rail_cfg_t;

endpackage

// *** logic/half_ms_timer.sv ***
/*
 * Countdown in half-millisecond ticks.
 * Assumes a 20 MHz clock; load restarts it, done pulses once at expiry.
 */
`timescale 1ns/100ps
`include "rail_timing_map.svh"

module half_ms_timer (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [8:0] ticks_i,
    output logic done_o
);
    logic [13:0] pre_r;
    logic [8:0] ticks_r;
    logic run_r;

    // ==========================================================
    // Prescaler plus tick counter; a reload always wins
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_r <= 14'h0000;
            ticks_r <= 9'h000;
            run_r <= 1'b0;
            done_o <= 1'b0;
        end else if (load_i) begin
            pre_r <= 14'h0000;
            ticks_r <= ticks_i;
            run_r <= (ticks_i != 9'h000);
            done_o <= (ticks_i == 9'h000);
        end else if (run_r) begin
            done_o <= 1'b0;
            if (pre_r == 14'(`HALF_MS_CYC - 1)) begin
                pre_r <= 14'h0000;
                ticks_r <= ticks_r - 9'h001;
                if (ticks_r == 9'h001) begin
                    run_r <= 1'b0;
                    done_o <= 1'b1;
                end
            end else begin
                pre_r <= pre_r + 14'h0001;
            end
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule

// *** logic/rail_timing.sv ***
/*
 * Rail soft-start, ramp slew and shutdown timing with power-off sequencing.
 * Assumes a classic Wishbone master on the same 20 MHz clock; chip enable
 * and the last-rail-off indication arrive asynchronously from pins.
 */
// Register access over Wishbone was decided locally.
// What this block does
// - Two-bit soft-start field picks 4, 2, 1 or 0.5 ms; resets to 01.
// - Two-bit shutdown field picks 4, 2, 1 or 0.5 ms; resets to 01.
// - Shutdown field sets shutdown slew only for buck option 00, 01, 10.
// - After chip enable falls and the off delay ends, shutdown count starts once last rail is off.
// - Shutdown expiry moves sequencer to standby, then onward to reset.
// - Two-bit ramp code picks 2, 4, 8 or 16 mV/us; resets to 10.
`timescale 1ns/100ps
`include "rail_timing_map.svh"

module rail_timing
    import rail_timing_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic chip_enable_input_i,
    input wire logic last_rail_off_i,
    output logic rail_en_o,
    output logic ramping_o,
    output logic [4:0] slew_mv_per_us_o,
    output logic shutdown_slew_valid_o,
    output logic [1:0] shutdown_slew_o,
    output logic standby_o,
    output logic seq_reset_o
);
    wb_req_t req;
    rail_cfg_t cfg_r;
    logic [1:0] buck_opt_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [1:0] cen_sync_r;
    logic [1:0] last_sync_r;
    logic cen_d_r;
    logic [7:0] ms_cnt_r;
    logic [14:0] step_r;
    logic tmr_load;
    logic [8:0] tmr_ticks;
    logic tmr_done;
    logic ramp_busy_r;
    logic ramp_start;
    logic hit;

    assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};
    assign hit = req.cyc && req.stb && !wb_ack_o;

    // ==========================================================
    // Pin synchronisers: first stage feeds only the second
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cen_sync_r <= 2'h0;
            last_sync_r <= 2'h0;
            cen_d_r <= 1'b0;
        end else begin
            cen_sync_r <= {cen_sync_r[0], chip_enable_input_i};
            last_sync_r <= {last_sync_r[0], last_rail_off_i};
            cen_d_r <= cen_sync_r[1];
        end
    end

    // ==========================================================
    // Register writes; settings are volatile copies of stored values
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r.soft_start <= `SOFT_RST;
            cfg_r.shutdown <= `SHUT_RST;
            cfg_r.slew <= `SLEW_RST;
            cfg_r.off_delay <= `OFF_DELAY_RST;
            buck_opt_r <= `OPT_RST;
        end else if (hit && req.we && req.sel[0]) begin
            if (req.adr == `RAMP_TIMING_ADDR) begin
                cfg_r.soft_start <= req.dat[`SOFT_LSB +: 2];
                cfg_r.shutdown <= req.dat[`SHUT_LSB +: 2];
                cfg_r.slew <= req.dat[`SLEW_LSB +: 2];
            end else if (req.adr == `OFF_DELAY_ADDR) begin
                cfg_r.off_delay <= req.dat[6:0];
            end else if (req.adr == `SEQ_CTRL_ADDR) begin
                buck_opt_r <= req.dat[1:0];
            end
        end
    end

    // ==========================================================
    // Bus answer: ack one cycle after request, unmapped reads zero
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= hit;
            wb_dat_o <= 32'h0000_0000;
            if (hit && !req.we) begin
                if (req.adr == `RAMP_TIMING_ADDR) begin
                    wb_dat_o[7:0] <= {cfg_r.soft_start, cfg_r.shutdown, cfg_r.slew, 2'h0};
                end else if (req.adr == `OFF_DELAY_ADDR) begin
                    wb_dat_o[6:0] <= cfg_r.off_delay;
                end else if (req.adr == `SEQ_CTRL_ADDR) begin
                    wb_dat_o[1:0] <= buck_opt_r;
                end else if (req.adr == `SEQ_STATUS_ADDR) begin
                    wb_dat_o[5:0] <= {ramp_busy_r, rail_en_o, 1'b0, 3'(state_r)};
                end
            end
        end
    end

    // ==========================================================
    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SEQ_ACTIVE: begin
                if (cen_d_r && !cen_sync_r[1]) begin
                    state_nxt = SEQ_OFF_DELAY;
                end
            end
            SEQ_OFF_DELAY: begin
                if (ms_cnt_r == {1'b0, cfg_r.off_delay}) begin
                    state_nxt = SEQ_WAIT_LAST;
                end
            end
            SEQ_WAIT_LAST: begin
                if (last_sync_r[1]) begin
                    state_nxt = SEQ_SHUTDOWN;
                end
            end
            SEQ_SHUTDOWN: begin
                if (tmr_done) begin
                    state_nxt = SEQ_STANDBY;
                end
            end
            SEQ_STANDBY: begin
                state_nxt = SEQ_RESET;
            end
            SEQ_RESET: begin
                if (cen_sync_r[1]) begin
                    state_nxt = SEQ_ACTIVE;
                end
            end
            default: begin
                state_nxt = SEQ_RESET;
            end
        endcase
    end

    // ==========================================================
    // Sequencer state and millisecond count of the power-off delay
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= SEQ_RESET;
            ms_cnt_r <= 8'h00;
            step_r <= 15'h0000;
        end else begin
            state_r <= state_nxt;
            if (state_r != SEQ_OFF_DELAY) begin
                ms_cnt_r <= 8'h00;
                step_r <= 15'h0000;
            end else if (step_r == 15'(`MS_CYC - 1)) begin
                step_r <= 15'h0000;
                ms_cnt_r <= ms_cnt_r + 8'h01;
            end else begin
                step_r <= step_r + 15'h0001;
            end
        end
    end

    // ==========================================================
    // One timer serves soft-start and shutdown; they never overlap
    assign ramp_start = (state_r == SEQ_RESET) && (state_nxt == SEQ_ACTIVE);
    assign tmr_load = ramp_start || (state_nxt == SEQ_SHUTDOWN && state_r != SEQ_SHUTDOWN);
    always_comb begin
        // Code 00 is 4 ms = 8 half-ms ticks, each step halves it
        tmr_ticks = `FOUR_MS_TICKS >> (ramp_start ? cfg_r.soft_start : cfg_r.shutdown);
    end

    half_ms_timer i_half_ms_timer (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .load_i(tmr_load),
        .ticks_i(tmr_ticks),
        .done_o(tmr_done)
    );

    // ==========================================================
    // Rail outputs, all registered
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ramp_busy_r <= 1'b0;
            rail_en_o <= 1'b0;
            ramping_o <= 1'b0;
            slew_mv_per_us_o <= `SLEW_OUT_RST;
            shutdown_slew_valid_o <= 1'b0;
            shutdown_slew_o <= 2'h0;
            standby_o <= 1'b0;
            seq_reset_o <= 1'b1;
        end else begin
            if (ramp_start) begin
                ramp_busy_r <= 1'b1;
            end else if (tmr_done || state_r != SEQ_ACTIVE) begin
                ramp_busy_r <= 1'b0;
            end
            // Gated by the next state so the flag never outlives the rail enable
            ramping_o <= ramp_busy_r && (state_nxt == SEQ_ACTIVE);
            rail_en_o <= (state_nxt == SEQ_ACTIVE) || (state_nxt == SEQ_OFF_DELAY);
            slew_mv_per_us_o <= 5'(`SLEW_BASE_MV_PER_US) << cfg_r.slew;
            // Option 11 leaves shutdown slew to other logic
            shutdown_slew_valid_o <= (buck_opt_r != `OPT_NO_SLEW);
            shutdown_slew_o <= cfg_r.shutdown;
            standby_o <= (state_nxt == SEQ_STANDBY);
            seq_reset_o <= (state_nxt == SEQ_RESET);
        end
    end
endmodule

// *** test/rail_timing_props.sv ***
/* Checker for the rail timing block: bus handshake, slew code, sequencing.
   Assumes it is bound to the top module and that there is a single clock. */
`timescale 1ns/100ps

module rail_timing_props (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic last_rail_off_i,
    input wire logic rail_en_o,
    input wire logic ramping_o,
    input wire logic [4:0] slew_mv_per_us_o,
    input wire logic standby_o,
    input wire logic seq_reset_o
);
    logic [15:0] last_cnt_r;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // =====
    // Last-rail-off age; saturates so that a long wait cannot wrap round
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_cnt_r <= 16'h0000;
        end else if (!last_rail_off_i) begin
            last_cnt_r <= 16'h0000;
        end else if (last_cnt_r != 16'hffff) begin
            last_cnt_r <= last_cnt_r + 16'h0001;
        end
    end

    // =====
    // Properties
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_slew_legal; slew_mv_per_us_o inside {5'h02, 5'h04, 5'h08, 5'h10}; endproperty
    property p_standby_next; standby_o |=> seq_reset_o && !standby_o; endproperty
    property p_standby_after; standby_o |-> last_cnt_r >= 16'h2710; endproperty
    property p_ramp_active; ramping_o |-> rail_en_o; endproperty
    property p_reset_off; seq_reset_o |-> !rail_en_o && !ramping_o; endproperty

    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_slew_legal: assert property (p_slew_legal) else $error("bad slew rate");
    a_standby_next: assert property (p_standby_next) else $error("no reset");
    a_standby_after: assert property (p_standby_after) else $error("early standby");
    a_ramp_active: assert property (p_ramp_active) else $error("ramp with rail off");
    a_reset_off: assert property (p_reset_off) else $error("rail on in reset");

    c_standby: cover property (standby_o);
    c_ramp: cover property ($rose(ramping_o));
    c_ack: cover property (wb_ack_o);
endmodule

// *** test/rail_timing_bench.sv ***
/* Bench for the rail timing block: Wishbone tasks and sequence tests.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/100ps
`include "rail_timing_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t: mismatch", $time); end end

module rail_timing_bench import rail_timing_pkg::*;;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    wb_req_t req;
    logic [31:0] wb_dat_o, rd_dat;
    logic [4:0] slew;
    logic [1:0] shut_slew;
    logic ack, chip_enable_input, last, rail_en, ramping, valid, standby, seq_rst;
    int fail_count = 0;
    int checks = 0;
    int n;

    rail_timing i_rail_timing (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
        .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
        .chip_enable_input_i(chip_enable_input), .last_rail_off_i(last), .rail_en_o(rail_en),
        .ramping_o(ramping), .slew_mv_per_us_o(slew), .shutdown_slew_valid_o(valid),
        .shutdown_slew_o(shut_slew), .standby_o(standby), .seq_reset_o(seq_rst));

    // Clock
    always #25 core_clk_i = ~core_clk_i;

    // =====
    // One classic cycle; request held until ack is sampled at an edge
    task automatic xfer(input logic we, input logic [9:0] adr, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge core_clk_i);
        req <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
        do begin
            @(posedge core_clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: no ack", $time);
        end
        rd_dat = wb_dat_o;
        req <= '0;
    endtask

    // Counts edges while a flag holds a level; bounded so a hang shows up
    task automatic span(ref logic s, input logic lvl);
        n = 0;
        while (s === lvl && n < 30000) begin
            @(posedge core_clk_i);
            n++;
        end
    endtask

    task give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // =====
    // Main sequence
    initial begin
        req = '0;
        chip_enable_input = 1'b0;
        last = 1'b0;
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        xfer(0, `RAMP_TIMING_ADDR, 0);
        `CHK(rd_dat, 32'h0000_0058)
        `CHK(slew, 5'h08)
        `CHK(valid, 1'b1)
        xfer(0, `OFF_DELAY_ADDR, 0);
        `CHK(rd_dat, 32'h0)
        xfer(1, `OFF_DELAY_ADDR, 32'hff);
        xfer(0, `OFF_DELAY_ADDR, 0);
        `CHK(rd_dat, 32'h7f)
        xfer(0, 10'h3fc, 0);
        `CHK(rd_dat, 32'h0)
        for (int k = 0; k < 4; k++) begin
            xfer(1, `RAMP_TIMING_ADDR, {24'h0, k[1:0], k[1:0], k[1:0], 2'b00});
            xfer(1, `SEQ_CTRL_ADDR, {30'h0, k[1:0]});
            xfer(0, `RAMP_TIMING_ADDR, 0);
            `CHK(rd_dat, {24'h0, k[1:0], k[1:0], k[1:0], 2'b00})
            `CHK(slew, 5'h02 << k)
            `CHK(shut_slew, k[1:0])
            `CHK(valid, k != 3)
        end
        // Shortest soft-start and shutdown, 1 ms off delay keeps the run short
        xfer(1, `OFF_DELAY_ADDR, 32'h1);
        chip_enable_input <= 1'b1;
        span(ramping, 1'b0);
        span(ramping, 1'b1);
        `CHK(n inside {[10000:10004]}, 1'b1)
        `CHK(rail_en, 1'b1)
        chip_enable_input <= 1'b0;
        span(rail_en, 1'b1);
        `CHK(n inside {[20000:20008]}, 1'b1)
        repeat (300) @(posedge core_clk_i);
        xfer(0, `SEQ_STATUS_ADDR, 0);
        `CHK(rd_dat[2:0], SEQ_WAIT_LAST)
        last <= 1'b1;
        span(standby, 1'b0);
        `CHK(n inside {[10000:10008]}, 1'b1)
        @(posedge core_clk_i);
        `CHK({standby, seq_rst}, 2'b01)
        xfer(0, `SEQ_STATUS_ADDR, 0);
        `CHK(rd_dat[2:0], SEQ_RESET)
        // Second power-up with soft-start code 10: two half-ms ticks
        xfer(1, `RAMP_TIMING_ADDR, 32'hbc);
        chip_enable_input <= 1'b1;
        span(ramping, 1'b0);
        span(ramping, 1'b1);
        `CHK(n inside {[20000:20004]}, 1'b1)
        `CHK(rail_en, 1'b1)
        give_verdict();
    end

    // Watchdog, about half again the expected run
    initial begin
        #(50 * 90000);
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule

bind rail_timing rail_timing_props i_rail_timing_props (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .last_rail_off_i(last_rail_off_i), .rail_en_o(rail_en_o), .ramping_o(ramping_o),
    .slew_mv_per_us_o(slew_mv_per_us_o), .standby_o(standby_o), .seq_reset_o(seq_reset_o));
